// ===== psg_top.sv
// Pulse gate, squelch and duty-cycle gain on a valid/ready sample stream.
// Assumes markers arrive on the samples they mark and an AXI4-Lite master.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module psg_top
    import psg_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_valid,
    input wire psg_in_s s_data,
    output logic s_ready,
    output logic m_valid,
    output psg_out_s m_data,
    input wire logic m_ready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // --------------------------------------------------------------------
    // Register bus
    // --------------------------------------------------------------------
    logic manual_r;
    logic [1:0] gtype_r;
    logic [CW-1:0] gdelay_r;
    logic [CW-1:0] glen_r;
    logic [DW-1:0] glevel_r;
    logic aw_got_r;
    logic w_got_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [CW-1:0] width_r;
    logic width_ok_r;
    logic [CW-1:0] pri_r;
    logic [15:0] duty_r;
    logic [15:0] gain_r;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    wire logic wr_go = aw_got_r && w_got_r && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
        end else begin
            s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready) && !wr_go;
            s_axi_wready <= !w_got_r && !(s_axi_wvalid && s_axi_wready) && !wr_go;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_r <= REG_GATE_LEVEL && awaddr_r[1:0] == 2'h0) ?
                               RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        logic [31:0] v;
        if (!aresetn) begin
            manual_r <= CTRL_MANUAL_RST;
            gtype_r <= GTYPE_RST;
            gdelay_r <= '0;
            glen_r <= '0;
            glevel_r <= '0;
        end else if (wr_go) begin
            case (awaddr_r)
                REG_CTRL: begin
                    v = merge({29'h0, gtype_r, manual_r}, wdata_r, wstrb_r);
                    manual_r <= v[CTRL_MANUAL_BIT];
                    gtype_r <= v[CTRL_GTYPE_LSB +: 2];
                end
                REG_GATE_DELAY: begin
                    v = merge({8'h0, gdelay_r}, wdata_r, wstrb_r);
                    gdelay_r <= v[CW-1:0];
                end
                REG_GATE_LEN: begin
                    v = merge({8'h0, glen_r}, wdata_r, wstrb_r);
                    glen_r <= v[CW-1:0];
                end
                REG_GATE_LEVEL: begin
                    v = merge({16'h0, glevel_r}, wdata_r, wstrb_r);
                    glevel_r <= v[DW-1:0];
                end
                default: begin
                    v = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= (s_axi_araddr <= REG_GAIN && s_axi_araddr[1:0] == 2'h0) ?
                               RESP_OKAY : RESP_SLVERR;
                case (s_axi_araddr)
                    REG_CTRL: s_axi_rdata <= {29'h0, gtype_r, manual_r};
                    REG_GATE_DELAY: s_axi_rdata <= {8'h0, gdelay_r};
                    REG_GATE_LEN: s_axi_rdata <= {8'h0, glen_r};
                    REG_GATE_LEVEL: s_axi_rdata <= {16'h0, glevel_r};
                    REG_WIDTH: s_axi_rdata <= {width_ok_r, 7'h0, width_r};
                    REG_PRI: s_axi_rdata <= {8'h0, pri_r};
                    REG_DUTY: s_axi_rdata <= {16'h0, duty_r};
                    REG_GAIN: s_axi_rdata <= {16'h0, gain_r};
                    default: s_axi_rdata <= 32'h0;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------------
    // Pulse measurement
    // --------------------------------------------------------------------
    logic [CW-1:0] pos_r;
    logic in_pulse_r;
    logic seen_start_r;
    logic pri_new_r;
    wire logic take = s_valid && s_ready;
    wire logic [CW-1:0] pos_inc = (&pos_r) ? pos_r : pos_r + 1'b1;
    wire logic [CW-1:0] cpos = s_data.start ? '0 : pos_inc;
    wire logic on_now = s_data.start || in_pulse_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_r <= '0;
            in_pulse_r <= 1'b0;
            seen_start_r <= 1'b0;
            width_r <= '0;
            width_ok_r <= 1'b0;
            pri_r <= '0;
            pri_new_r <= 1'b0;
        end else begin
            pri_new_r <= 1'b0;
            if (take) begin
                pos_r <= cpos;
                if (s_data.start) begin
                    in_pulse_r <= !s_data.stop;
                    seen_start_r <= 1'b1;
                    if (seen_start_r) begin
                        pri_r <= pos_inc;
                        pri_new_r <= 1'b1;
                    end
                end
                if (s_data.stop && on_now) begin
                    in_pulse_r <= 1'b0;
                    width_r <= cpos + 1'b1;
                    width_ok_r <= (cpos + 1'b1) >= CW'(MIN_PULSE_SMP);
                end
            end
        end
    end

    // --------------------------------------------------------------------
    // Gate generation
    // --------------------------------------------------------------------
    logic [CW-1:0] g_delay;
    logic [CW-1:0] g_len;
    logic [DW:0] mag;
    logic gate;

    always_comb begin
        if (manual_r) begin
            g_delay = gdelay_r;
            g_len = glen_r;
        end else begin
            g_delay = width_r >> 3;
            g_len = width_r - (width_r >> 2);
        end
        mag = {1'b0, s_data.i[DW-1] ? -s_data.i : s_data.i} +
              {1'b0, s_data.q[DW-1] ? -s_data.q : s_data.q};
        case (gtype_r)
            GTYPE_NONE: gate = 1'b1;
            GTYPE_LEVEL: gate = on_now && width_ok_r && (mag >= {1'b0, glevel_r});
            default: gate = on_now && width_ok_r && (cpos >= g_delay) &&
                ({1'b0, cpos} < {1'b0, g_delay} + {1'b0, g_len});
        endcase
    end

    // --------------------------------------------------------------------
    // Duty cycle and gain divider
    // --------------------------------------------------------------------
    psg_div_e div_st_r;
    logic [39:0] num_r;
    logic [39:0] quo_r;
    logic [CW:0] rem_r;
    logic [CW-1:0] den_r;
    logic [5:0] step_r;
    wire logic [CW:0] trial = {rem_r[CW-1:0], num_r[39]};
    wire logic ge = trial >= {1'b0, den_r};
    wire logic [CW-1:0] eff_len = (gtype_r == GTYPE_NONE) ? pri_r : g_len;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_st_r <= PSG_DIV_IDLE;
            num_r <= '0;
            quo_r <= '0;
            rem_r <= '0;
            den_r <= '0;
            step_r <= '0;
            duty_r <= DUTY_FULL;
            gain_r <= GAIN_UNITY;
        end else begin
            case (div_st_r)
                PSG_DIV_IDLE: begin
                    if (pri_new_r && pri_r != '0 && eff_len != '0) begin
                        num_r <= {8'h00, pri_r, 8'h00};
                        den_r <= eff_len;
                        rem_r <= '0;
                        step_r <= '0;
                        div_st_r <= PSG_DIV_GAIN;
                    end
                end
                PSG_DIV_DUTY, PSG_DIV_GAIN: begin
                    rem_r <= ge ? trial - {1'b0, den_r} : trial;
                    quo_r <= {quo_r[38:0], ge};
                    num_r <= {num_r[38:0], 1'b0};
                    step_r <= step_r + 1'b1;
                    if (step_r == 6'(DIV_STEPS - 1)) begin
                        step_r <= '0;
                        rem_r <= '0;
                        if (div_st_r == PSG_DIV_GAIN) begin
                            gain_r <= (|quo_r[38:15]) ? DUTY_FULL : {quo_r[14:0], ge};
                            num_r <= {den_r, 16'h0000};
                            den_r <= pri_r;
                            div_st_r <= PSG_DIV_DUTY;
                        end else begin
                            duty_r <= (|quo_r[38:15]) ? DUTY_FULL : {quo_r[14:0], ge};
                            div_st_r <= PSG_DIV_IDLE;
                        end
                    end
                end
                default: div_st_r <= PSG_DIV_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------------
    // Squelch and output buffer
    // --------------------------------------------------------------------
    function automatic logic [DW-1:0] scale(input logic [DW-1:0] x, input logic [15:0] g);
        logic signed [DW+16:0] p;
        logic signed [DW+8:0] s;
        p = $signed(x) * $signed({1'b0, g});
        s = p[DW+16:8];
        if (s > $signed({10'h000, 15'h7FFF})) begin
            return 16'h7FFF;
        end else if (s < -$signed({10'h000, 15'h7FFF}) - 1) begin
            return 16'h8000;
        end
        return s[DW-1:0];
    endfunction

    psg_out_s push_d;
    logic [15:0] use_gain;
    psg_out_s buf_r [DEPTH];
    logic [$clog2(DEPTH):0] cnt_r;
    logic [$clog2(DEPTH):0] cnt_nxt;
    wire logic pop = m_valid && m_ready;

    always_comb begin
        use_gain = (gtype_r == GTYPE_NONE) ? GAIN_UNITY : gain_r;
        push_d.gate = gate;
        push_d.i = gate ? scale(s_data.i, use_gain) : '0;
        push_d.q = gate ? scale(s_data.q, use_gain) : '0;
        cnt_nxt = cnt_r + (take ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
            s_ready <= 1'b0;
            m_valid <= 1'b0;
            m_data <= '0;
            for (int k = 0; k < DEPTH; k++) begin
                buf_r[k] <= '0;
            end
        end else begin
            cnt_r <= cnt_nxt;
            s_ready <= cnt_nxt < DEPTH;
            m_valid <= cnt_nxt != '0;
            if (pop) begin
                for (int k = 0; k < DEPTH - 1; k++) begin
                    buf_r[k] <= buf_r[k+1];
                end
            end
            if (take) begin
                buf_r[int'(cnt_r) - (pop ? 1 : 0)] <= push_d;
            end
            if (pop) begin
                m_data <= (cnt_r > 1) ? buf_r[1] : push_d;
            end else if (cnt_r == '0) begin
                m_data <= push_d;
            end
        end
    end

endmodule

// ===== psg_pkg.sv
// Constants, register map and carrier types of the pulse gate and squelch block.
// Assumes one sample clock shared with the register bus.
// Behaviour
// - Measure pulse width and repetition interval from per-pulse start and end markers.
// - Pass samples only while the gate is open inside the pulse; zero the others.
// - Edge gating opens a gate inside the pulse, 75% of measured width long.
// - Duty cycle is gate width divided by measured waveform period.
// - Squelch fully blanks the stream between pulses.
// - Gated samples get a gain derived from the duty cycle.
// - Detection is automatic after reset; gate centred on the pulse's central 75%.
// - Gate type none passes every sample ungated.
// - Level gating opens the gate by a software-supplied gate level.
// - Manual mode opens gate after programmed delay for programmed length.
// - Pulses shorter than ten samples (100 ns at 100 Msa/s) are rejected; the code instead closes the gate on the pulse that follows a short one.
// - Gating and duty logic keep working below 1% duty cycle.
// - The detector's gate signal drives the squelch's blank/pass select directly.
package psg_pkg;

    localparam int DW = 16;
    localparam int CW = 24;

    // --------------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------------
    localparam int SAMPLE_RATE_MSPS = 100;
    localparam int MIN_PULSE_NS = 100;
    localparam int MIN_PULSE_SMP = (MIN_PULSE_NS * SAMPLE_RATE_MSPS + 999) / 1000;
    localparam int DIV_STEPS = 40;

    // --------------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_GATE_DELAY = 8'h04;
    localparam logic [7:0] REG_GATE_LEN = 8'h08;
    localparam logic [7:0] REG_GATE_LEVEL = 8'h0C;
    localparam logic [7:0] REG_WIDTH = 8'h10;
    localparam logic [7:0] REG_PRI = 8'h14;
    localparam logic [7:0] REG_DUTY = 8'h18;
    localparam logic [7:0] REG_GAIN = 8'h1C;

    localparam int CTRL_MANUAL_BIT = 0;
    localparam int CTRL_GTYPE_LSB = 1;
    localparam int WIDTH_VALID_BIT = 31;

    localparam logic [1:0] GTYPE_EDGE = 2'h0;
    localparam logic [1:0] GTYPE_LEVEL = 2'h1;
    localparam logic [1:0] GTYPE_NONE = 2'h2;

    localparam logic CTRL_MANUAL_RST = 1'b0;
    localparam logic [1:0] GTYPE_RST = GTYPE_EDGE;
    localparam logic [15:0] GAIN_UNITY = 16'h0100;
    localparam logic [15:0] DUTY_FULL = 16'hFFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PSG_DIV_IDLE = 3'b001,
        PSG_DIV_DUTY = 3'b010,
        PSG_DIV_GAIN = 3'b100
    } psg_div_e;

    typedef struct packed {
        logic [DW-1:0] i;
        logic [DW-1:0] q;
        logic start;
        logic stop;
    } psg_in_s;

    typedef struct packed {
        logic [DW-1:0] i;
        logic [DW-1:0] q;
        logic gate;
    } psg_out_s;

endpackage

// ===== psg_checker_properties.sv
// Port-level checks for the pulse gate and squelch block.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module psg_checker
    import psg_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_valid,
    input wire logic s_ready,
    input wire logic m_valid,
    input wire psg_out_s m_data,
    input wire logic m_ready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------------
    // Occupancy and write tracking
    // ------------------------------------------------------------------
    logic [2:0] fill_r;
    logic aw_r;
    logic w_r;
    logic [7:0] wa_r;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire [7:0] wa = aw_hs ? s_axi_awaddr : wa_r;
    wire wa_bad = wa > REG_GATE_LEVEL || |wa[1:0];
    always_ff @(posedge aclk) begin
        if (!aresetn) fill_r <= '0;
        else fill_r <= fill_r + 3'(s_valid && s_ready) - 3'(m_valid && m_ready);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || (s_axi_bvalid && s_axi_bready)) begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
        end else begin
            if (aw_hs) aw_r <= 1'b1;
            if (w_hs) w_r <= 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        if (aw_hs) wa_r <= s_axi_awaddr;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_done;
        (aw_hs && (w_r || w_hs)) || (w_hs && aw_r);
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence take_empty;
        s_valid && s_ready && fill_r == 3'h0;
    endsequence
    a_blank_off_time: assert property (
        m_valid && !m_data.gate |-> m_data.i == '0 && m_data.q == '0)
        else $error("closed gate output not zero");
    a_out_hold: assert property (m_valid && !m_ready |=> m_valid && $stable(m_data))
        else $error("output changed while stalled");
    a_no_overrun: assert property (s_ready |-> fill_r < DEPTH)
        else $error("ready with full buffer");
    a_out_pairs: assert property (m_valid |-> fill_r != 3'h0)
        else $error("output without input");
    a_stream_answer: assert property (take_empty |=> m_valid)
        else $error("sample not forwarded");
    a_write_answer: assert property (wr_done |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    a_ro_refused: assert property (
        wr_done |-> ##2 s_axi_bresp == ($past(wa_bad, 2) ? RESP_SLVERR : RESP_OKAY))
        else $error("wrong write response");
    a_read_answer: assert property (rd_take |=> s_axi_rvalid)
        else $error("read not answered");
    a_unmapped_read: assert property (
        rd_take ##0 s_axi_araddr > 8'h1C |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
        else $error("unmapped read accepted");
    a_read_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while waiting");
endmodule

bind psg_top psg_checker #(.DEPTH(DEPTH)) psg_checker_i (.aclk(aclk), .aresetn(aresetn),
    .s_valid(s_valid), .s_ready(s_ready), .m_valid(m_valid), .m_data(m_data), .m_ready(m_ready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== psg_src.sv
// Upstream sample source with per-pulse start and stop markers.
// Assumes callers enter its tasks right after a rising clock edge.
`timescale 1ns/1ps
module psg_src
    import psg_pkg::*;
(
    input wire logic aclk,
    input wire logic s_ready,
    output logic s_valid,
    output psg_in_s s_data
);
    initial begin
        s_valid = 1'b0;
        s_data = '0;
    end
    // Holds the sample until the block takes it
    task automatic push(logic [15:0] i, logic [15:0] q, logic st, logic sp);
        bit ok;
        s_valid <= 1'b1;
        s_data <= {i, q, st, sp};
        do begin
            @(negedge aclk);
            ok = s_ready;
            @(posedge aclk);
        end while (!ok);
    endtask
    // Released data lines show no stale sample
    task automatic idle();
        s_valid <= 1'b0;
        s_data <= ~s_data;
    endtask
endmodule

// ===== tb.sv
// Self-checking bench for the pulse gate and squelch block.
// Assumes psg_pkg, the design and the checker are compiled first.
`timescale 1ns/1ps
module tb
    import psg_pkg::*;
;
    logic aclk = 0, aresetn = 0, m_ready = 0, stall = 0, s_ready, s_valid, m_valid;
    psg_in_s s_data;
    psg_out_s m_data;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int n_fail = 0, samples_checked = 0, cyc = 0;
    int wprev = 0, lastpri = 0, gty = 0, man = 0, dly = 0, glen = 0, lvl = 0;
    int gn = 256, gn_pend = 256, have = 0, dty = 65535;
    psg_out_s exp_q[$], got_q[$];
    psg_top #(.DEPTH(2)) psg_top_i (.aclk(aclk), .aresetn(aresetn), .s_valid(s_valid),
        .s_data(s_data), .s_ready(s_ready), .m_valid(m_valid), .m_data(m_data),
        .m_ready(m_ready), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    psg_src psg_src_i (.aclk(aclk), .s_ready(s_ready), .s_valid(s_valid), .s_data(s_data));
    always #10 aclk = ~aclk;
    // ------------------------------------------------------------------
    // Far-side stalls, output capture and hang limit
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        m_ready <= !stall && (cyc % 5 != 3);
        if (m_valid && m_ready) got_q.push_back(m_data);
        if (cyc == 40000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic chk_w(string nm, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_out(psg_out_s e, psg_out_s g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch sample expected %h seen %h", e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        bit ao, wo, done;
        logic [1:0] r;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        done = 0;
        while (!done) begin
            @(negedge aclk);
            ao = awvalid && awready;
            wo = wvalid && wready;
            done = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ao) awvalid <= 0;
            if (wo) wvalid <= 0;
        end
        bready <= 0;
        chk_w("bresp", 32'(er), 32'(r));
    endtask
    task automatic rdc(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
        bit ao, rv, done;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        done = 0;
        while (!done) begin
            @(negedge aclk);
            ao = arvalid && arready;
            rv = rvalid;
            done = rvalid && rready;
            if (done) chk_w("rdata", ed, rdata);
            if (done) chk_w("rresp", 32'(er), 32'(rresp));
            @(posedge aclk);
            if (ao) arvalid <= 0;
            rready <= rv && !done;
        end
    endtask
    function automatic logic [15:0] sat(logic [15:0] x, int g);
        longint p;
        p = (longint'($signed(x)) * g) >>> 8;
        if (p > 32767) p = 32767;
        if (p < -32768) p = -32768;
        return p[15:0];
    endfunction
    function automatic psg_out_s expv(int k, logic [15:0] i, logic [15:0] q, bit inp);
        bit g;
        int h;
        h = wprev >> 3;
        if (gty == 2) return {i, q, 1'b1};
        if (!inp || wprev < MIN_PULSE_SMP) g = 0;
        else if (man) g = k >= dly && k < dly + glen;
        else if (gty == 1) g = int'(i) + int'(q) >= lvl;
        else g = k >= h && k < h + wprev - (wprev >> 2);
        return g ? {sat(i, gn), sat(q, gn), 1'b1} : '0;
    endfunction
    // One pulse of w samples and gap off-time samples, with expectations
    task automatic pulse(int w, int gap);
        int len;
        gn = gn_pend;
        if (have) begin
            len = gty == 2 ? lastpri : man ? glen : wprev - (wprev >> 2);
            gn_pend = lastpri * 256 / len;
            if (gn_pend > 65535) gn_pend = 65535;
            dty = len * 65536 / lastpri;
        end
        have = 1;
        for (int k = 0; k < w + gap; k++) begin
            logic [15:0] iv;
            iv = k < w ? 16'(k << 4) : 16'h0008;
            psg_src_i.push(iv, 16'h0020, k == 0, k == w - 1);
            exp_q.push_back(expv(k, iv, 16'h0020, k < w));
        end
        wprev = w;
        lastpri = w + gap;
    endtask
    task automatic drain(string nm);
        psg_src_i.idle();
        for (int t = 0; t < 3000 && got_q.size() < exp_q.size(); t++) @(posedge aclk);
        chk_w("count", 32'(exp_q.size()), 32'(got_q.size()));
        while (exp_q.size() > 0 && got_q.size() > 0) chk_out(exp_q.pop_front(), got_q.pop_front());
        exp_q.delete();
        got_q.delete();
        $display("test %s done", nm);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        rdc(REG_CTRL, 32'h0, RESP_OKAY);
        rdc(REG_DUTY, 32'(DUTY_FULL), RESP_OKAY);
        rdc(REG_GAIN, 32'(GAIN_UNITY), RESP_OKAY);
        wr(REG_WIDTH, 32'h1, RESP_SLVERR);
        rdc(8'h20, 32'h0, RESP_SLVERR);
        $display("test regs done");
        wr(REG_CTRL, 32'(GTYPE_NONE) << CTRL_GTYPE_LSB, RESP_OKAY);
        gty = 2;
        stall = 1;
        fork
            pulse(12, 100);
            begin
                repeat (12) @(negedge aclk);
                chk_w("s_ready", 32'h0, 32'(s_ready));
                chk_w("early", 32'h0, 32'(got_q.size()));
                stall = 0;
            end
        join
        pulse(12, 100);
        drain("none");
        wr(REG_CTRL, 32'h0, RESP_OKAY);
        gty = 0;
        pulse(16, 100);
        pulse(16, 100);
        pulse(9, 100);
        drain("edge");
        rdc(REG_WIDTH, 32'h9, RESP_OKAY);
        pulse(16, 100);
        drain("short");
        wr(REG_CTRL, 32'h1, RESP_OKAY);
        wr(REG_GATE_DELAY, 32'h3, RESP_OKAY);
        wr(REG_GATE_LEN, 32'h4, RESP_OKAY);
        rdc(REG_GATE_DELAY, 32'h3, RESP_OKAY);
        man = 1;
        dly = 3;
        glen = 4;
        pulse(16, 100);
        pulse(16, 100);
        drain("manual");
        wr(REG_CTRL, 32'h0, RESP_OKAY);
        man = 0;
        repeat (3) pulse(10, 1090);
        drain("low duty");
        rdc(REG_DUTY, 32'(dty), RESP_OKAY);
        rdc(REG_GAIN, 32'(gn_pend), RESP_OKAY);
        rdc(REG_PRI, 32'd1100, RESP_OKAY);
        rdc(REG_WIDTH, 32'h8000000A, RESP_OKAY);
        wr(REG_CTRL, 32'(GTYPE_LEVEL) << CTRL_GTYPE_LSB, RESP_OKAY);
        wr(REG_GATE_LEVEL, 32'h100, RESP_OKAY);
        gty = 1;
        lvl = 256;
        pulse(16, 100);
        drain("level");
        complete_run();
    end
endmodule
